// >>> src/pdsc_map.svh
`ifndef PDSC_MAP_SVH
`define PDSC_MAP_SVH

// ------------------------------------------------------------
// register offset
// ------------------------------------------------------------
`define PDSC_OFF_DSC 8'h70

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PDSC_EN_LSB 0
`define PDSC_MPS_LSB 5
`define PDSC_MRRS_LSB 12
`define PDSC_RETRY_BIT 15
`define PDSC_FLAG_LSB 16
`define PDSC_PEND_BIT 21

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PDSC_RST_EN 4'h0
`define PDSC_RST_MPS 3'h0
`define PDSC_RST_MRRS 3'h2
`define PDSC_RST_RETRY 1'b0
`define PDSC_RST_FLAGS 4'h0

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PDSC_RDATA_LAT 1

`endif

// >>> src/pdsc_pkg.sv
package pdsc_pkg;

    typedef enum logic [2:0]
    {
        PDSC_RD_128 = 3'b000,
        PDSC_RD_256 = 3'b001,
        PDSC_RD_512 = 3'b010,
        PDSC_RD_1K = 3'b011,
        PDSC_RD_2K = 3'b100,
        PDSC_RD_4K = 3'b101,
        PDSC_RD_RSV6 = 3'b110,
        PDSC_RD_RSV7 = 3'b111
    } pdsc_mrrs_t;

    // one bit per error class, msb first
    typedef struct packed
    {
        logic ur;
        logic fatal;
        logic nonfatal;
        logic cor;
    } pdsc_err_t;

endpackage

// >>> src/pdsc_top.sv
// What this block does
// - Read requests are capped to the size set by the 3-bit size field.
// - After reset the read size field selects 512 bytes.
// - A non-fatal error sets its flag, whatever its report enable.
// - A fatal error sets its flag, whatever its report enable.
// - An unsupported request sets its flag, whatever its report enable.
// - The read-only pending flag is high while a completion is awaited.
// - An error is reported upward only when its enable bit is one.
`timescale 1ns/1ps
`include "pdsc_map.svh"

module pdsc_top
#(
    parameter int ADDR_W = 8,
    parameter int PEND_W = 4
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire pdsc_pkg::pdsc_err_t ERR_EVENT,
    output pdsc_pkg::pdsc_err_t ERR_REPORT,
    input wire logic REQ_ISSUE,
    input wire logic CPL_DONE,
    output logic TXN_PENDING,
    input wire logic RD_REQ_VALID,
    input wire logic [12:0] RD_REQ_BYTES,
    output logic RD_CAP_VALID,
    output logic [12:0] RD_CAP_BYTES,
    output logic [12:0] MAX_RD_BYTES
);
    import pdsc_pkg::*;

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (ADDR_W < 8)
    begin : g_bad_addr
        $error("ADDR_W too narrow for register offset");
    end
    if (PEND_W < 1 || PEND_W > 16)
    begin : g_bad_pend
        $error("PEND_W out of range");
    end

    // ------------------------------------------------------------
    // size decode
    // ------------------------------------------------------------
    function automatic logic [12:0] size_bytes(input pdsc_mrrs_t code);
        case (code)
            PDSC_RD_128: size_bytes = 13'h0080;
            PDSC_RD_256: size_bytes = 13'h0100;
            PDSC_RD_512: size_bytes = 13'h0200;
            PDSC_RD_1K: size_bytes = 13'h0400;
            PDSC_RD_2K: size_bytes = 13'h0800;
            PDSC_RD_4K: size_bytes = 13'h1000;
            default: size_bytes = 13'h0080;
        endcase
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [3:0] en_q;
    logic [2:0] mps_q;
    pdsc_mrrs_t mrrs_q;
    logic retry_q;
    logic [3:0] flags_q;
    logic [3:0] flags_d;
    logic [PEND_W-1:0] pend_q;
    logic [PEND_W-1:0] pend_d;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire hit = REG_ADDR == ADDR_W'(`PDSC_OFF_DSC);
    wire wr_hit = CE & REG_WR & hit;
    wire [3:0] wr_clr = wr_hit ?
        REG_WDATA[`PDSC_FLAG_LSB +: 4] : 4'h0;
    wire [2:0] wr_mrrs = REG_WDATA[`PDSC_MRRS_LSB +: 3];
    // reserved size codes are not stored
    wire mrrs_ok = wr_mrrs != PDSC_RD_RSV6 &&
        wr_mrrs != PDSC_RD_RSV7;
    wire [3:0] ev = ERR_EVENT;
    wire [31:0] dsc_val = {10'h000, TXN_PENDING, 1'b0, flags_q, retry_q,
        mrrs_q, 4'h0, mps_q, 1'b0, en_q};
    wire [31:0] rdata_d = (REG_RD & hit) ? dsc_val : 32'h0000_0000;
    wire [12:0] max_bytes = size_bytes(mrrs_q);
    wire [12:0] cap_d = (RD_REQ_BYTES > max_bytes) ?
        max_bytes : RD_REQ_BYTES;
    wire pend_full = &pend_q;
    wire pend_empty = pend_q == '0;
    wire pend_inc = REQ_ISSUE & ~CPL_DONE & ~pend_full;
    wire pend_dec = CPL_DONE & ~REQ_ISSUE & ~pend_empty;

    assign pend_d = pend_inc ? pend_q + PEND_W'(1) :
        pend_dec ? pend_q - PEND_W'(1) : pend_q;

    // ------------------------------------------------------------
    // sticky error flags, set beats clear
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_flag
            assign flags_d[gi] = ev[gi] |
                (flags_q[gi] & ~wr_clr[gi]);

            chk_flag_set: assert property (
                @(posedge CLK) disable iff (RST)
                CE && ev[gi] |=> flags_q[gi])
                else $error("error flag not set by event");

            chk_flag_keep: assert property (
                @(posedge CLK) disable iff (RST)
                flags_q[gi] && !wr_clr[gi] |=> flags_q[gi])
                else $error("error flag lost without a one written");
        end
    endgenerate

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            en_q <= `PDSC_RST_EN;
            mps_q <= `PDSC_RST_MPS;
            mrrs_q <= pdsc_mrrs_t'(`PDSC_RST_MRRS);
            retry_q <= `PDSC_RST_RETRY;
            flags_q <= `PDSC_RST_FLAGS;
        end
        else if (CE)
        begin
            flags_q <= flags_d;
            if (wr_hit)
            begin
                en_q <= REG_WDATA[`PDSC_EN_LSB +: 4];
                mps_q <= REG_WDATA[`PDSC_MPS_LSB +: 3];
                retry_q <= REG_WDATA[`PDSC_RETRY_BIT];
                if (mrrs_ok)
                    mrrs_q <= pdsc_mrrs_t'(wr_mrrs);
            end
        end
    end

    // ------------------------------------------------------------
    // outstanding completions
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            pend_q <= '0;
            TXN_PENDING <= 1'b0;
        end
        else if (CE)
        begin
            pend_q <= pend_d;
            TXN_PENDING <= pend_d != '0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            REG_RDATA <= 32'h0000_0000;
            ERR_REPORT <= '0;
            RD_CAP_VALID <= 1'b0;
            RD_CAP_BYTES <= 13'h0000;
            MAX_RD_BYTES <= 13'h0200;
        end
        else if (CE)
        begin
            REG_RDATA <= rdata_d;
            ERR_REPORT <= ev & en_q;
            RD_CAP_VALID <= RD_REQ_VALID;
            RD_CAP_BYTES <= RD_REQ_VALID ? cap_d : 13'h0000;
            MAX_RD_BYTES <= max_bytes;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_cap_limit: assert property (@(posedge CLK) disable iff (RST)
        CE && RD_REQ_VALID |=> RD_CAP_VALID &&
        RD_CAP_BYTES <= size_bytes(pdsc_mrrs_t'($past(mrrs_q))) &&
        RD_CAP_BYTES <= $past(RD_REQ_BYTES))
        else $error("read request not capped to size field");

    chk_rsvd_code: assert property (@(posedge CLK) disable iff (RST)
        mrrs_q != PDSC_RD_RSV6 && mrrs_q != PDSC_RD_RSV7)
        else $error("reserved read size code stored");

    chk_size_reset: assert property (@(posedge CLK)
        $past(RST) && !RST |-> mrrs_q == PDSC_RD_512 &&
        flags_q == 4'h0)
        else $error("wrong read size or flags after reset");

    chk_pend_issue: assert property (@(posedge CLK) disable iff (RST)
        CE && REQ_ISSUE && !CPL_DONE |=> TXN_PENDING ##0
        (!TXN_PENDING || pend_q != '0))
        else $error("pending not raised after issue");

    chk_err_report: assert property (@(posedge CLK) disable iff (RST)
        CE |=> ERR_REPORT == ($past(ev) & $past(en_q)))
        else $error("report does not follow enable");

    chk_flag_clear: assert property (@(posedge CLK) disable iff (RST)
        CE && wr_clr[2] && !ev[2] |=> !flags_q[2])
        else $error("fatal flag not cleared by one");

endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
    import pdsc_pkg::*;

    logic CLK, RST, CE, REG_WR, REG_RD, REQ_ISSUE, CPL_DONE, RD_REQ_VALID;
    logic RD_CAP_VALID, TXN_PENDING;
    logic [7:0] REG_ADDR;
    logic [31:0] REG_WDATA, REG_RDATA, d, v;
    logic [3:0] x;
    logic [12:0] RD_REQ_BYTES, RD_CAP_BYTES, MAX_RD_BYTES, m;
    pdsc_err_t ERR_EVENT, ERR_REPORT;
    int n_errors = 0;
    int checked = 0;
    int seed = 32'h82d9;

    pdsc_top dut_u (.CLK(CLK), .RST(RST), .CE(CE), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .ERR_EVENT(ERR_EVENT),
        .ERR_REPORT(ERR_REPORT), .REQ_ISSUE(REQ_ISSUE),
        .CPL_DONE(CPL_DONE), .TXN_PENDING(TXN_PENDING),
        .RD_REQ_VALID(RD_REQ_VALID), .RD_REQ_BYTES(RD_REQ_BYTES),
        .RD_CAP_VALID(RD_CAP_VALID), .RD_CAP_BYTES(RD_CAP_BYTES),
        .MAX_RD_BYTES(MAX_RD_BYTES));

    initial
    begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    // ------------------------------
    // checking and closing
    // ------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    function automatic logic [12:0] max_of(input int c);
        return 13'h80 << c;
    endfunction

    // register image after a write of w and error events f
    function automatic logic [31:0] dsc_exp(input logic [31:0] w,
        input logic [3:0] f);
        return (w & 32'h0000_f0ef) | (32'(f) << 16);
    endfunction

    // ------------------------------
    // bus and stimulus tasks
    // ------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= v;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1;
        d = REG_RDATA;
    endtask

    task automatic cap(input logic [12:0] r);
        @(posedge CLK);
        RD_REQ_VALID <= 1'b1;
        RD_REQ_BYTES <= r;
        @(posedge CLK);
        RD_REQ_VALID <= 1'b0;
        #1;
        chk("cap valid", 32'(RD_CAP_VALID), 32'h1);
        chk("cap bytes", 32'(RD_CAP_BYTES), 32'(r > m ? m : r));
    endtask

    task automatic ev(input logic [3:0] v, input logic [3:0] en);
        @(posedge CLK);
        ERR_EVENT <= v;
        @(posedge CLK);
        ERR_EVENT <= 4'h0;
        #1;
        chk("report", 32'(ERR_REPORT), 32'(v & en));
    endtask

    task automatic pend(input logic i, input logic c, input logic e);
        @(posedge CLK);
        REQ_ISSUE <= i;
        CPL_DONE <= c;
        @(posedge CLK);
        REQ_ISSUE <= 1'b0;
        CPL_DONE <= 1'b0;
        #1;
        chk("pending", 32'(TXN_PENDING), 32'(e));
    endtask

    // ------------------------------
    // main sequence
    // ------------------------------
    initial
    begin
        {RST, CE} = 2'b11;
        {REG_WR, REG_RD, REQ_ISSUE, CPL_DONE, RD_REQ_VALID} = 5'h0;
        {REG_ADDR, REG_WDATA, RD_REQ_BYTES, ERR_EVENT} = '0;
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        rd(8'h70);
        chk("dsc reset", d, 32'h2000);
        chk("max reset", 32'(MAX_RD_BYTES), 32'h200);
        @(posedge CLK);
        #1;
        chk("rdata idle", REG_RDATA, 32'h0);
        // codes 6 and 7 must leave code 5 in place
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h70, 32'(c) << 12);
            rd(8'h70);
            chk("size code", 32'(d[14:12]), c < 6 ? c : 5);
            m = max_of(c < 6 ? c : 5);
            chk("max bytes", 32'(MAX_RD_BYTES), 32'(m));
            cap(m);
            cap(m + 13'h1);
            cap(13'($random(seed)));
        end
        for (int e = 0; e < 2; e++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                wr(8'h70, e ? 32'h200f : 32'h2000);
                ev(4'h1 << k, e ? 4'hf : 4'h0);
                rd(8'h70);
                chk("flag", 32'(d[19:16]), 1 << k);
                wr(8'h70, e ? 32'h200f : 32'h2000);
                rd(8'h70);
                chk("flag kept", 32'(d[19:16]), 1 << k);
                wr(8'h70, 32'h2000 | (32'h1 << (16 + k)));
                rd(8'h70);
                chk("flag clear", 32'(d[19:16]), 32'h0);
            end
        end
        // event and write-one-clear in one cycle: set wins
        fork
            wr(8'h70, 32'h0004_2000);
            ev(4'h4, 4'h0);
        join
        rd(8'h70);
        chk("set over clear", 32'(d[19:16]), 32'h4);
        // clock enable low: write and events ignored
        @(posedge CLK);
        CE <= 1'b0;
        wr(8'h70, 32'h000f_1000);
        ev(4'hf, 4'h0);
        @(posedge CLK);
        CE <= 1'b1;
        rd(8'h70);
        chk("frozen", d, 32'h0004_2000);
        // random control words and events
        for (int i = 0; i < 16; i++)
        begin
            v = ($random(seed) & 32'h0000_f0ef) | 32'h000f_0000;
            if (v[14:12] > 3'h5)
                v[14] = 1'b0;
            x = 4'($random(seed));
            wr(8'h70, v);
            ev(x, v[3:0]);
            rd(8'h70);
            chk("dsc random", d, dsc_exp(v, x));
            m = max_of(v[14:12]);
            chk("max random", 32'(MAX_RD_BYTES), 32'(m));
            cap(13'($random(seed)));
        end
        // reset in mid-run clears flags and returns size to 512
        ev(4'hf, v[3:0]);
        @(posedge CLK);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        rd(8'h70);
        chk("dsc reset again", d, 32'h2000);
        chk("max reset again", 32'(MAX_RD_BYTES), 32'h200);
        pend(1'b1, 1'b1, 1'b0);
        pend(1'b0, 1'b1, 1'b0);
        pend(1'b1, 1'b0, 1'b1);
        pend(1'b1, 1'b0, 1'b1);
        pend(1'b0, 1'b1, 1'b1);
        rd(8'h70);
        chk("pend bit", 32'(d[21]), 32'h1);
        pend(1'b0, 1'b1, 1'b0);
        rd(8'h70);
        chk("pend bit", 32'(d[21]), 32'h0);
        rd(8'h74);
        chk("unmapped", d, 32'h0);
        stop_test;
    end

    initial
    begin
        #1000000;
        n_errors++;
        stop_test;
    end
endmodule
